// File: design/gpio_port_data_control.sv
// gpio port: direction, masked data register, pad control and interrupts
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns

// Overview of operation
// RULE1 - eight identical ports from this block
// RULE2 - ordinary pins reset undriven, config zero
// RULE3 - debug pins reset altfunc, enable, pullup
// RULE4 - any reset restores both default groups
// RULE5 - direction 0: data bit samples pin
// RULE6 - direction 1: data bit drives pad
// RULE7 - address bits nine..two mask data
// RULE8 - masked write alters selected bits only
// RULE9 - masked read returns zero elsewhere
// RULE10 - edge, both, or level interrupts maskable
// RULE11 - alternate function hands pin to peripheral
// RULE12 - one port interrupt; write one clears
// RULE13 - eight pins; pad driven when gpio output
module gpio_port_data_control #(
    parameter gpio_port_pkg::pins_t DebugPins = 8'h00                 // RULE1
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   clkEn,
    input  wire gpio_port_pkg::addr_t   regAddr,
    input  wire gpio_port_pkg::word_t   regWdata,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output      gpio_port_pkg::word_t   regRdata,
    input  wire gpio_port_pkg::pins_t   padIn,
    output      gpio_port_pkg::pins_t   padOut,
    output      gpio_port_pkg::pins_t   padOe,
    output      gpio_port_pkg::pins_t   pullUpEn,
    output      gpio_port_pkg::pins_t   pullDownEn,
    input  wire gpio_port_pkg::pins_t   altOut,
    input  wire gpio_port_pkg::pins_t   altOe,
    output      gpio_port_pkg::pins_t   altIn,
    output      logic                   portIrq
);
    import gpio_port_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic pins_t maskOf(input addr_t a);
        maskOf = a[MaskMsb:MaskLsb];
    endfunction : maskOf

    function automatic pins_t merge(input pins_t old, input pins_t nw,
                                    input pins_t sel);
        merge = (old & ~sel) | (nw & sel);
    endfunction : merge

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pins_t pinDirection_q, pinDirection_d;
    pins_t pinDataValue_q, pinDataValue_d;
    pins_t altFunctionSelect_q, altFunctionSelect_d;
    pins_t digitalInputEnable_q, digitalInputEnable_d;
    pins_t pullUpEnable_q, pullUpEnable_d;
    pins_t pullDownEnable_q, pullDownEnable_d;
    pins_t intSense_q, intSense_d;
    pins_t intBoth_q, intBoth_d;
    pins_t intEvent_q, intEvent_d;
    pins_t interruptMask_q, interruptMask_d;
    pins_t edgeStat_q, edgeStat_d;
    pins_t padSync1_q, padSync2_q, padPrev_q;
    word_t rdata_q, rdata_d;

    logic  inWindow;
    pins_t wrData, mask, inLevel, rise, fall, edgeHit, levelHit, rawStat;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        wrData   = regWdata[PinCount-1:0];
        mask     = maskOf(regAddr);
        inWindow = (regAddr & DataWinMask) == DataWinBase;            // RULE7
        inLevel  = padSync2_q & digitalInputEnable_q;
        rise     = inLevel & ~padPrev_q;
        fall     = ~inLevel & padPrev_q;
        edgeHit  = (intBoth_q & (rise | fall))                        // RULE10
                 | (~intBoth_q & intEvent_q & rise)
                 | (~intBoth_q & ~intEvent_q & fall);
        levelHit = intSense_q & (intEvent_q ~^ inLevel);              // RULE10
        rawStat  = (edgeStat_q & ~intSense_q) | levelHit;

        pinDirection_d       = pinDirection_q;
        altFunctionSelect_d  = altFunctionSelect_q;
        digitalInputEnable_d = digitalInputEnable_q;
        pullUpEnable_d       = pullUpEnable_q;
        pullDownEnable_d     = pullDownEnable_q;
        intSense_d           = intSense_q;
        intBoth_d            = intBoth_q;
        intEvent_d           = intEvent_q;
        interruptMask_d      = interruptMask_q;
        // input pins keep sampling the pad where digitalInputEnable is set, else load 0
        pinDataValue_d = merge(pinDataValue_q, inLevel,
                               ~pinDirection_q);                       // RULE5
        edgeStat_d     = edgeStat_q;

        if (regWrite) begin
            if (inWindow)
                pinDataValue_d = merge(pinDataValue_d, wrData,
                                       mask & pinDirection_q);          // RULE8
            unique case (regAddr)
                DirOffset:   pinDirection_d       = wrData;
                IntSenseOff: intSense_d           = wrData;
                IntBothOff:  intBoth_d            = wrData;
                IntEventOff: intEvent_d           = wrData;
                IntMaskOff:  interruptMask_d      = wrData;
                IntClearOff: edgeStat_d           = edgeStat_q & ~wrData; // RULE12
                AltFuncOff:  altFunctionSelect_d  = wrData;
                PullUpOff:   pullUpEnable_d       = wrData;
                PullDownOff: pullDownEnable_d     = wrData;
                DigEnOff:    digitalInputEnable_d = wrData;
                default:     ;
            endcase
        end
        // a new edge wins over a clear in the same cycle
        edgeStat_d = edgeStat_d | edgeHit;

        rdata_d = WordZero;
        if (regRead) begin
            if (inWindow)
                rdata_d = {{(DataWidth-PinCount){1'b0}},
                           pinDataValue_q & mask};                      // RULE9
            else begin
                unique case (regAddr)
                    DirOffset:   rdata_d[PinCount-1:0] = pinDirection_q;
                    IntSenseOff: rdata_d[PinCount-1:0] = intSense_q;
                    IntBothOff:  rdata_d[PinCount-1:0] = intBoth_q;
                    IntEventOff: rdata_d[PinCount-1:0] = intEvent_q;
                    IntMaskOff:  rdata_d[PinCount-1:0] = interruptMask_q;
                    RawStatOff:  rdata_d[PinCount-1:0] = rawStat;
                    MaskStatOff: rdata_d[PinCount-1:0] =
                                     rawStat & interruptMask_q;
                    AltFuncOff:  rdata_d[PinCount-1:0] = altFunctionSelect_q;
                    PullUpOff:   rdata_d[PinCount-1:0] = pullUpEnable_q;
                    PullDownOff: rdata_d[PinCount-1:0] = pullDownEnable_q;
                    DigEnOff:    rdata_d[PinCount-1:0] = digitalInputEnable_q;
                    default:     rdata_d = WordZero;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin                                              // RULE4
            pinDirection_q       <= PinsZero;                          // RULE2
            pinDataValue_q       <= PinsZero;
            altFunctionSelect_q  <= DebugPins;                         // RULE3
            digitalInputEnable_q <= DebugPins;                         // RULE3
            pullUpEnable_q       <= DebugPins;                         // RULE3
            pullDownEnable_q     <= PinsZero;                          // RULE2
            intSense_q           <= PinsZero;
            intBoth_q            <= PinsZero;
            intEvent_q           <= PinsZero;
            interruptMask_q      <= PinsZero;
            edgeStat_q           <= PinsZero;
            padSync1_q           <= PinsZero;
            padSync2_q           <= PinsZero;
            padPrev_q            <= PinsZero;
            rdata_q              <= WordZero;
        end else if (clkEn) begin
            pinDirection_q       <= pinDirection_d;
            pinDataValue_q       <= pinDataValue_d;
            altFunctionSelect_q  <= altFunctionSelect_d;
            digitalInputEnable_q <= digitalInputEnable_d;
            pullUpEnable_q       <= pullUpEnable_d;
            pullDownEnable_q     <= pullDownEnable_d;
            intSense_q           <= intSense_d;
            intBoth_q            <= intBoth_d;
            intEvent_q           <= intEvent_d;
            interruptMask_q      <= interruptMask_d;
            edgeStat_q           <= edgeStat_d;
            padSync1_q           <= padIn;
            padSync2_q           <= padSync1_q;
            padPrev_q            <= padSync2_q & digitalInputEnable_q;
            rdata_q              <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // pads and outputs
    // ------------------------------------------------------------
    assign regRdata   = rdata_q;
    assign padOut     = (altFunctionSelect_q & altOut)
                      | (~altFunctionSelect_q & pinDataValue_q);       // RULE6
    assign padOe      = (altFunctionSelect_q & altOe)                  // RULE11
                      | (~altFunctionSelect_q & pinDirection_q);       // RULE13
    assign altIn      = padSync2_q & digitalInputEnable_q;             // RULE11
    assign pullUpEn   = pullUpEnable_q;
    assign pullDownEn = pullDownEnable_q;
    assign portIrq    = |(rawStat & interruptMask_q);                  // RULE12
endmodule : gpio_port_data_control

// File: design/gpio_port_pkg.sv
// package: register map, widths and reset values of the gpio port
package gpio_port_pkg;
    localparam int          PinCount     = 8;
    localparam int          AddrWidth    = 12;
    localparam int          DataWidth    = 32;
    localparam int          MaskLsb      = 2;
    localparam int          MaskMsb      = 9;
    typedef logic [PinCount-1:0]  pins_t;
    typedef logic [AddrWidth-1:0] addr_t;
    typedef logic [DataWidth-1:0] word_t;
    // data window covers 0x000..0x3FC
    localparam addr_t       DataWinBase  = 12'h000;
    localparam addr_t       DataWinMask  = 12'hC00;
    localparam addr_t       DirOffset    = 12'h400;
    localparam addr_t       IntSenseOff  = 12'h404;
    localparam addr_t       IntBothOff   = 12'h408;
    localparam addr_t       IntEventOff  = 12'h40C;
    localparam addr_t       IntMaskOff   = 12'h410;
    localparam addr_t       RawStatOff   = 12'h414;
    localparam addr_t       MaskStatOff  = 12'h418;
    localparam addr_t       IntClearOff  = 12'h41C;
    localparam addr_t       AltFuncOff   = 12'h420;
    localparam addr_t       PullUpOff    = 12'h510;
    localparam addr_t       PullDownOff  = 12'h514;
    localparam addr_t       DigEnOff     = 12'h51C;
    localparam pins_t       PinsZero     = 8'h00;
    localparam word_t       WordZero     = 32'h0000_0000;
endpackage : gpio_port_pkg

// File: testbench/gpio_pad_model.sv
// partner: external pads with pulls and an optional outside drive
`timescale 1ns/1ns
module gpio_pad_model (
    input  wire gpio_port_pkg::pins_t padOut,
    input  wire gpio_port_pkg::pins_t padOe,
    input  wire gpio_port_pkg::pins_t pullUpEn,
    input  wire gpio_port_pkg::pins_t pullDownEn,
    input  wire gpio_port_pkg::pins_t extVal,
    input  wire gpio_port_pkg::pins_t extEn,
    output      gpio_port_pkg::pins_t padIn
);
    import gpio_port_pkg::*;
    // floating pad shows the inverse of the current padOut level
    always_comb begin
        for (int i = 0; i < PinCount; i++) begin
            padIn[i] = padOe[i] ? padOut[i] : extEn[i] ? extVal[i] :
                pullUpEn[i] ? 1'b1 : pullDownEn[i] ? 1'b0 : ~padOut[i];
        end
    end
endmodule : gpio_pad_model

// File: testbench/gpio_port_chk.sv
// checker: port-level assertions of the gpio port
`timescale 1ns/1ns
module gpio_port_chk #(
    parameter gpio_port_pkg::pins_t DebugPins = 8'h00
) (
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire gpio_port_pkg::addr_t regAddr,
    input wire gpio_port_pkg::word_t regWdata,
    input wire logic                 regWrite,
    input wire logic                 regRead,
    input wire gpio_port_pkg::word_t regRdata,
    input wire gpio_port_pkg::pins_t padOut,
    input wire gpio_port_pkg::pins_t padOe,
    input wire gpio_port_pkg::pins_t pullUpEn,
    input wire gpio_port_pkg::pins_t pullDownEn,
    input wire gpio_port_pkg::pins_t altOut,
    input wire gpio_port_pkg::pins_t altOe,
    input wire logic                 portIrq
);
    import gpio_port_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    rd_idle_a: assert property (!$past(regRead) |-> regRdata == WordZero)
        else $error("read data outside read slot");
    rd_upper_a: assert property (regRdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    rst_dflt_a: assert property ($rose(rst_n) |-> padOe == (altOe & DebugPins)
        && pullUpEn == DebugPins && pullDownEn == PinsZero)
        else $error("reset defaults wrong");
    rd_mask_a: assert property (regRead && regAddr[11:10] == 2'h0 |=>
        (regRdata[7:0] & ~$past(regAddr[9:2])) == PinsZero)
        else $error("unmasked read bit");
    rd_unmap_a: assert property (regRead && regAddr == 12'hFFC |=>
        regRdata == WordZero) else $error("unmapped read not zero");
    out_hold_a: assert property (!regWrite && $stable(altOut) && $stable(altOe)
        |=> $stable(padOut & padOe))
        else $error("pad output moved without write");
    wr_mask_a: assert property (regWrite && regAddr[11:10] == 2'h0 |=>
        ((padOut ^ $past(padOut)) & padOe & ~$past(regAddr[9:2])) == PinsZero)
        else $error("masked bit changed");
    irq_mask_a: assert property (regWrite && regAddr == IntMaskOff &&
        regWdata[7:0] == PinsZero |=> !portIrq)
        else $error("irq with all masked");
endmodule : gpio_port_chk

bind gpio_port_data_control gpio_port_chk #(.DebugPins(DebugPins)) chk_i (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .padOut(padOut), .padOe(padOe), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn), .altOut(altOut), .altOe(altOe),
    .portIrq(portIrq));

// File: testbench/gpio_port_data_control_tb_top.sv
// testbench: directed scenarios for one gpio port
`timescale 1ns/1ns
module gpio_port_data_control_tb_top;
    import gpio_port_pkg::*;
    localparam pins_t Dbg = 8'h0F;
    logic  clock = 0, rst_n = 0, regWrite = 0, regRead = 0, portIrq;
    logic  clkEn = 1'b1;
    addr_t regAddr = 12'h000;
    word_t regWdata = WordZero, regRdata, rd;
    pins_t padIn, padOut, padOe, pullUpEn, pullDownEn, altIn;
    pins_t extVal = 8'h00, extEn = 8'h00, altOut = 8'h00, altOe = 8'h00;
    int    n_errors = 0, compares = 0, cyc = 0;
    gpio_port_data_control #(.DebugPins(Dbg)) gpio_port_data_control_i (
        .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .altOut(altOut),
        .altOe(altOe), .altIn(altIn), .portIrq(portIrq));
    gpio_pad_model gpio_pad_model_i (.padOut(padOut), .padOe(padOe),
        .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .extVal(extVal),
        .extEn(extEn), .padIn(padIn));
    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            summarize();
        end
    end
    task summarize();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task check(input word_t seen, input word_t exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task wr(input addr_t a, input word_t d);
        @(posedge clock);
        regAddr <= a; regWdata <= d; regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr
    task rdw(input addr_t a);
        @(posedge clock);
        regAddr <= a; regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 rd = regRdata;
    endtask : rdw
    task reset_dut();
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
    endtask : reset_dut
    task test_defaults();
        rdw(PullUpOff); check(rd, {24'h0, Dbg});
        rdw(AltFuncOff); check(rd, {24'h0, Dbg});
        rdw(DigEnOff); check(rd, {24'h0, Dbg});
        rdw(PullDownOff); check(rd, WordZero);
        rdw(DirOffset); check(rd, WordZero);
        $display("defaults done");
    endtask : test_defaults
    task test_output();
        wr(AltFuncOff, WordZero); wr(DirOffset, 32'hFF); wr(12'h3FC, WordZero);
        wr(12'h098, 32'hEB);
        rdw(12'h3FC); check(rd, 32'h22);
        check({24'h0, padOut}, 32'h22);
        check({24'h0, padOe}, 32'hFF);
        rdw(12'h0C4); check(rd, 32'h20);
        rdw(12'hFFC); check(rd, WordZero);
        $display("output done");
    endtask : test_output
    task test_input();
        wr(DirOffset, WordZero); wr(DigEnOff, 32'hFF);
        extEn <= 8'hFF; extVal <= 8'hA5;
        repeat (4) @(posedge clock);
        rdw(12'h3FC); check(rd, 32'hA5);
        rdw(12'h0C4); check(rd, 32'h21);
        check({24'h0, altIn}, 32'hA5);
        $display("input done");
    endtask : test_input
    task test_irq();
        extVal <= 8'hA4; wr(IntEventOff, 32'h1); wr(IntMaskOff, 32'h1);
        wr(IntClearOff, 32'hFF);
        extVal <= 8'hA5; repeat (5) @(posedge clock);
        #1 check({31'h0, portIrq}, 32'h1);
        rdw(RawStatOff); check(rd, 32'h1);
        wr(IntMaskOff, WordZero); @(posedge clock);
        #1 check({31'h0, portIrq}, WordZero);
        wr(IntMaskOff, 32'h1); wr(IntClearOff, 32'h1); @(posedge clock);
        #1 check({31'h0, portIrq}, WordZero);
        wr(IntSenseOff, 32'h1); @(posedge clock);
        #1 check({31'h0, portIrq}, 32'h1);
        wr(IntSenseOff, WordZero); wr(IntBothOff, 32'h1);
        wr(IntClearOff, 32'hFF); @(posedge clock);
        #1 check({31'h0, portIrq}, WordZero);
        extVal <= 8'hA4; repeat (5) @(posedge clock);
        #1 check({31'h0, portIrq}, 32'h1);
        wr(IntClearOff, 32'hFF); wr(IntMaskOff, WordZero);
        $display("irq done");
    endtask : test_irq
    task test_rst();
        altOe <= 8'h05; altOut <= 8'h01; reset_dut(); @(posedge clock);
        #1 check({24'h0, padOe}, 32'h05);
        check({24'h0, padOut & padOe}, 32'h01);
        check({24'h0, pullUpEn}, {24'h0, Dbg});
        check({24'h0, pullDownEn}, WordZero);
        $display("reset done");
    endtask : test_rst
    task test_freeze();
        clkEn <= 1'b0;
        wr(DirOffset, 32'hFF);
        clkEn <= 1'b1;
        rdw(DirOffset); check(rd, WordZero);
        $display("freeze done");
    endtask : test_freeze
    initial begin
        @(posedge clock);
        reset_dut();
        test_defaults(); test_output(); test_input(); test_irq(); test_rst();
        test_freeze();
        summarize();
    end
endmodule : gpio_port_data_control_tb_top
